/* File: hdl/clock_mode_pkg.sv */
// Package: constants, enumerations and carriers of the clock-mode controller
package clock_mode_pkg;

	// ==================================================================
	// Clock rates
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int SUB_CLK_HZ = 32_768;
	// Sub clock ticks are one-cycle enables; the ratio rounds down
	localparam int SUB_DIV_DEFAULT = SYS_CLK_HZ / SUB_CLK_HZ;

	// ==================================================================
	// Register byte addresses on the APB
	localparam logic [7:0] ADDR_CLOCK_MODE = 8'h00;
	localparam logic [7:0] ADDR_IDLE_FLAGS = 8'h04;
	localparam logic [7:0] ADDR_MODE_STATUS = 8'h08;

	// ==================================================================
	// clock_mode_control fields and reset value
	localparam int CM_HIGH_SEL_BIT = 0;
	localparam int CM_IDLE_HALT_BIT = 1;
	localparam int CM_HIGH_RDY_BIT = 2;
	localparam int CM_LOW_RDY_BIT = 3;
	localparam int CM_FAST_WAKE_BIT = 4;
	localparam int CM_DIV_SEL_LSB = 5;
	localparam logic [7:0] CLOCK_MODE_RESET = 8'h03;

	// ==================================================================
	// idle_clock_and_reset_flags fields and reset value
	localparam int IF_WDT_RST_BIT = 0;
	localparam int IF_LVR_INV_BIT = 1;
	localparam int IF_LOWVOLT_BIT = 2;
	localparam int IF_KEEP_SYSCLK_BIT = 7;
	localparam logic [7:0] IDLE_FLAGS_RESET = 8'h00;

	// ==================================================================
	// Clock selection codes {high_clock_select, sysclk_divider_select}
	localparam logic [3:0] SEL_SUB = 4'h0;
	localparam logic [3:0] SEL_RESET = 4'h8;
	localparam logic [2:0] DIV_SEL_MIN = 3'h2;

	// ==================================================================
	// Oscillator start-up counts, in cycles of the oscillator itself
	localparam int STABLE_W = 11;
	localparam int HI_STABLE_CRYSTAL = 1024;
	localparam int HI_STABLE_RC = 16;
	localparam int HI_STABLE_EXT = 2;
	localparam int LO_STABLE_CRYSTAL = 1024;
	localparam int LO_STABLE_RC = 2;

	// ==================================================================
	// Enumerations
	typedef enum logic [1:0] {
		FAST_CRYSTAL_OSC,
		EXTERNAL_RC_OSC,
		INTERNAL_FAST_RC_OSC,
		EXTERNAL_CLOCK_INPUT
	} high_osc_t;

	typedef enum logic {
		SLOW_CRYSTAL_OSC,
		INTERNAL_SLOW_RC_OSC
	} low_osc_t;

	typedef enum logic [2:0] {
		RUN_MODE,
		IDLE_SYSCLK_ON,
		IDLE_SYSCLK_OFF,
		SLEEP_SUBCLK_ON,
		DEEP_SLEEP_ALL_OFF
	} op_mode_t;

	typedef enum logic [1:0] {
		SW_IDLE,
		SW_DRAIN,
		SW_CATCH
	} switch_t;

	// ==================================================================
	// Carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic haltReq;
		logic wakeReq;
		logic lvrEvent;
		logic lvrLevelInvalid;
		logic wdtCtrlReset;
	} event_in_t;

	typedef struct packed {
		logic sysClkEn;
		logic cpuClkEn;
		logic subClkEn;
		logic [6:0] hiTapEn;
	} clk_en_t;

endpackage : clock_mode_pkg

/* File: hdl/rate_divider.sv */
// Module: divider that turns sys_clk into a one-cycle enable pulse
`timescale 1ns/100ps
`default_nettype none

module rate_divider #(
	parameter int DIVISOR = 610
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control and output
	input wire logic enable,
	output var logic tick
);

	// ==================================================================
	// Elaboration check
	localparam int CW = $clog2(DIVISOR);

	if (DIVISOR < 2) begin : g_bad_divisor
		$error("rate_divider needs a divisor of at least 2");
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} div_state_t;

	div_state_t q;
	div_state_t n;

	// ==================================================================
	// Counter; held at zero while stopped so restart is a full period
	always_comb begin
		n = q;
		n.tick = 1'b0;
		if (!enable) begin
			n.cnt = '0;
		end else if (q.cnt == CW'(DIVISOR - 1)) begin
			n.cnt = '0;
			n.tick = 1'b1;
		end else begin
			n.cnt = q.cnt + 1'b1;
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign tick = q.tick;

endmodule : rate_divider

`default_nettype wire

/* File: hdl/system_clock_mode_control.sv */
// Module: system clock source, divider, halt and wake-up mode control
//
// Notes on behaviour
// [R01] Divider select picks sub clock or divided high
// [R02] High select bit picks undivided high clock
// [R03] Moving to sub clock stops high oscillator
// [R04] Divided high taps stop with high oscillator
// [R05] Fast wake runs sub clock after crystal wake
// [R06] Low ready flag clear in deepest sleep
// [R07] High ready clears when stopped, sets when stable
// [R08] Halt with idle bit enters idle mode
// [R09] Halt without idle bit enters sleep
// [R10] Unused flag register bits read zero
// [R11] Low-voltage reset sets flag, software clears
// [R12] Bad voltage level sets flag, software clears
// [R13] Watchdog control reset sets flag
// [R14] Fast wake only from sub-on sleep, clock-off idle
// [R15] Crystal fast wake: sub first, then crystal
// [R16] RC and external clocks wake without fast wake
// [R17] Deepest sleep only with watchdog, detector off
// [R18] Entering halt sets powerdown, clears timeout
// [R19] Source changes leave no runt clock pulses
// [R20] Switch waits until target oscillator ready
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module system_clock_mode_control #(
	parameter clock_mode_pkg::high_osc_t HIGH_OSC =
		clock_mode_pkg::FAST_CRYSTAL_OSC,
	parameter clock_mode_pkg::low_osc_t LOW_OSC =
		clock_mode_pkg::INTERNAL_SLOW_RC_OSC,
	parameter int SUB_DIV = clock_mode_pkg::SUB_DIV_DEFAULT
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// APB slave
	input wire clock_mode_pkg::apb_req_t apbReq,
	output clock_mode_pkg::apb_rsp_t apbRsp,
	// Halt, wake and reset-cause events; watchdog and detector state
	input wire clock_mode_pkg::event_in_t events,
	input wire logic wdtEnable,
	input wire logic lowvolt_detect_enable,
	// Clock enables for CPU and peripherals
	output clock_mode_pkg::clk_en_t clkEn,
	// Oscillator controls and status-register strobes
	output logic highOscEnable,
	output logic subOscEnable,
	output logic powerdownSet,
	output logic timeoutClear
);

	// ==================================================================
	// Elaboration check and start-up counts
	if (SUB_DIV < 2) begin : g_bad_sub_div
		$error("SUB_DIV must be at least 2");
	end

	localparam logic [clock_mode_pkg::STABLE_W-1:0] HI_STABLE =
		(HIGH_OSC == clock_mode_pkg::FAST_CRYSTAL_OSC) ?
		clock_mode_pkg::STABLE_W'(clock_mode_pkg::HI_STABLE_CRYSTAL) :
		(HIGH_OSC == clock_mode_pkg::EXTERNAL_CLOCK_INPUT) ?
		clock_mode_pkg::STABLE_W'(clock_mode_pkg::HI_STABLE_EXT) :
		clock_mode_pkg::STABLE_W'(clock_mode_pkg::HI_STABLE_RC);
	localparam logic [clock_mode_pkg::STABLE_W-1:0] LO_STABLE =
		(LOW_OSC == clock_mode_pkg::SLOW_CRYSTAL_OSC) ?
		clock_mode_pkg::STABLE_W'(clock_mode_pkg::LO_STABLE_CRYSTAL) :
		clock_mode_pkg::STABLE_W'(clock_mode_pkg::LO_STABLE_RC);

	// ==================================================================
	// State
	typedef struct packed {
		clock_mode_pkg::op_mode_t mode;
		clock_mode_pkg::switch_t sw;
		logic [3:0] sel;
		logic [2:0] divSel;
		logic fastWakeEn;
		logic idleOnHalt;
		logic highSel;
		logic keepSysclk;
		logic lvrFlag;
		logic lvrInvFlag;
		logic wdtRstFlag;
		logic hiReady;
		logic loReady;
		logic [clock_mode_pkg::STABLE_W-1:0] hiCnt;
		logic [clock_mode_pkg::STABLE_W-1:0] loCnt;
		logic [5:0] hiDiv;
		logic fastWake;
		logic [31:0] rdata;
		logic pdfSet;
		logic toClr;
		logic sysTick;
		logic cpuTick;
		logic subTick;
		logic [6:0] taps;
	} st_t;

	st_t q;
	st_t n;

	logic subRaw;
	logic subOn;
	logic hiOn;
	logic [3:0] regSel;
	logic [3:0] target;

	// ==================================================================
	// Helpers
	function automatic logic needs_high(input logic [3:0] sel);
		return sel[3] | (sel[2:0] >= clock_mode_pkg::DIV_SEL_MIN);
	endfunction : needs_high

	// Low divider bits that must all be one for a tap tick
	function automatic logic [5:0] tap_mask(input logic [2:0] div);
		case (div)
			3'h2: tap_mask = 6'h3F;
			3'h3: tap_mask = 6'h1F;
			3'h4: tap_mask = 6'h0F;
			3'h5: tap_mask = 6'h07;
			3'h6: tap_mask = 6'h03;
			3'h7: tap_mask = 6'h01;
			default: tap_mask = 6'h00;
		endcase
	endfunction : tap_mask

	function automatic logic src_tick(input logic [3:0] sel,
			input logic hiRun, input logic [5:0] hiDiv,
			input logic subRun);
		logic [5:0] m;
		m = tap_mask(sel[2:0]);
		if (sel[3]) begin
			src_tick = hiRun;
		end else if (!needs_high(sel)) begin
			src_tick = subRun;
		end else begin
			src_tick = hiRun && ((hiDiv & m) == m);
		end
	endfunction : src_tick

	// ==================================================================
	// Sub clock enable generator
	rate_divider #(
		.DIVISOR(SUB_DIV)
	) u_sub_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.enable(subOn),
		.tick(subRaw)
	);

	// Oscillator requests; the sub clock dies only in deepest sleep
	assign regSel = {q.highSel, q.divSel};
	// [R05] sub clock stands in
	assign target = q.fastWake ? clock_mode_pkg::SEL_SUB : regSel;
	assign subOn = (q.mode != clock_mode_pkg::DEEP_SLEEP_ALL_OFF);
	// [R03] high off on sub
	assign hiOn = ((q.mode == clock_mode_pkg::RUN_MODE) ||
		(q.mode == clock_mode_pkg::IDLE_SYSCLK_ON)) &&
		(needs_high(regSel) || needs_high(q.sel));

	// ==================================================================
	// Next-state logic
	always_comb begin
		logic hiRun;
		logic subRun;
		logic oldTick;
		logic newTick;
		logic oldReady;
		logic tgtReady;
		logic running;
		logic wr;
		logic [5:0] m;
		n = q;
		hiRun = hiOn && q.hiReady;
		// Gated by subOn so a tick in flight dies with the oscillator
		subRun = subRaw && q.loReady && subOn;
		oldTick = src_tick(q.sel, hiRun, q.hiDiv, subRun);
		newTick = src_tick(target, hiRun, q.hiDiv, subRun);
		oldReady = needs_high(q.sel) ? hiRun : q.loReady;
		tgtReady = needs_high(target) ? hiRun : q.loReady;
		running = (q.mode == clock_mode_pkg::RUN_MODE) ||
			(q.mode == clock_mode_pkg::IDLE_SYSCLK_ON);
		wr = apbReq.psel && apbReq.penable && apbReq.pwrite;
		m = 6'h00;
		n.pdfSet = 1'b0;
		n.toClr = 1'b0;

		// [R07] high ready counter
		if (!hiOn) begin
			n.hiCnt = '0;
			n.hiReady = 1'b0;
		end else if (!q.hiReady) begin
			if (q.hiCnt == HI_STABLE - 1'b1) begin
				n.hiReady = 1'b1;
			end else begin
				n.hiCnt = q.hiCnt + 1'b1;
			end
		end

		// [R06] low ready counter
		if (!subOn) begin
			n.loCnt = '0;
			n.loReady = 1'b0;
		end else if (!q.loReady && subRaw) begin
			if (q.loCnt == LO_STABLE - 1'b1) begin
				n.loReady = 1'b1;
			end else begin
				n.loCnt = q.loCnt + 1'b1;
			end
		end

		// [R04] taps stop with oscillator
		if (!hiOn) begin
			n.hiDiv = 6'h00;
		end else if (hiRun) begin
			n.hiDiv = q.hiDiv + 6'h01;
		end
		n.taps[0] = hiRun;
		for (int k = 1; k < 7; k++) begin
			m = 6'((1 << k) - 1);
			n.taps[k] = hiRun && ((q.hiDiv & m) == m);
		end

		// [R19] drain old, skip a new tick
		case (q.sw)
			clock_mode_pkg::SW_IDLE: begin
				// [R20] wait for target ready
				if ((target != q.sel) && tgtReady) begin
					n.sw = clock_mode_pkg::SW_DRAIN;
				end
			end
			clock_mode_pkg::SW_DRAIN: begin
				if (target == q.sel) begin
					n.sw = clock_mode_pkg::SW_IDLE;
				end else if (oldTick || !oldReady) begin
					n.sw = clock_mode_pkg::SW_CATCH;
				end
			end
			clock_mode_pkg::SW_CATCH: begin
				if (!tgtReady) begin
					n.sw = clock_mode_pkg::SW_IDLE;
				end else if (newTick) begin
					n.sel = target;
					n.sw = clock_mode_pkg::SW_IDLE;
				end
			end
			default: begin
				n.sw = clock_mode_pkg::SW_IDLE;
			end
		endcase

		// [R01] tick of the chosen source
		// [R02] undivided high when selected
		n.sysTick = running && oldTick &&
			(q.sw != clock_mode_pkg::SW_CATCH);
		n.cpuTick = n.sysTick && (q.mode == clock_mode_pkg::RUN_MODE);
		n.subTick = subRun;

		// [R15] back to crystal once ready
		if (q.fastWake && q.hiReady) begin
			n.fastWake = 1'b0;
		end

		// Halt entry and wake-up
		case (q.mode)
			clock_mode_pkg::RUN_MODE: begin
				if (events.haltReq) begin
					// [R18] powerdown and timeout strobes
					n.pdfSet = 1'b1;
					n.toClr = 1'b1;
					if (q.idleOnHalt) begin
						// [R08] idle keeps clock if asked
						n.mode = q.keepSysclk ?
							clock_mode_pkg::IDLE_SYSCLK_ON :
							clock_mode_pkg::IDLE_SYSCLK_OFF;
					end else if (wdtEnable || lowvolt_detect_enable) begin
						// [R09] sleep, sub clock kept
						n.mode = clock_mode_pkg::SLEEP_SUBCLK_ON;
					end else begin
						// [R17] deepest sleep, all off
						n.mode = clock_mode_pkg::DEEP_SLEEP_ALL_OFF;
					end
				end
			end
			clock_mode_pkg::IDLE_SYSCLK_ON,
			clock_mode_pkg::IDLE_SYSCLK_OFF,
			clock_mode_pkg::SLEEP_SUBCLK_ON,
			clock_mode_pkg::DEEP_SLEEP_ALL_OFF: begin
				if (events.wakeReq) begin
					n.mode = clock_mode_pkg::RUN_MODE;
					// [R14] only with sub clock alive
					// [R16] crystal only, others ignore
					if ((HIGH_OSC == clock_mode_pkg::FAST_CRYSTAL_OSC) &&
							q.fastWakeEn && needs_high(regSel) &&
							((q.mode == clock_mode_pkg::SLEEP_SUBCLK_ON) ||
							(q.mode == clock_mode_pkg::IDLE_SYSCLK_OFF))) begin
						n.fastWake = 1'b1;
					end
				end
			end
			default: begin
				n.mode = clock_mode_pkg::RUN_MODE;
			end
		endcase

		// Register writes in the access phase; ready flags are read-only
		if (wr && (apbReq.paddr == clock_mode_pkg::ADDR_CLOCK_MODE)) begin
			n.divSel = apbReq.pwdata[clock_mode_pkg::CM_DIV_SEL_LSB +: 3];
			n.fastWakeEn = apbReq.pwdata[clock_mode_pkg::CM_FAST_WAKE_BIT];
			n.idleOnHalt = apbReq.pwdata[clock_mode_pkg::CM_IDLE_HALT_BIT];
			n.highSel = apbReq.pwdata[clock_mode_pkg::CM_HIGH_SEL_BIT];
		end
		if (wr && (apbReq.paddr == clock_mode_pkg::ADDR_IDLE_FLAGS)) begin
			n.keepSysclk =
				apbReq.pwdata[clock_mode_pkg::IF_KEEP_SYSCLK_BIT];
			n.lvrFlag = q.lvrFlag &
				apbReq.pwdata[clock_mode_pkg::IF_LOWVOLT_BIT];
			n.lvrInvFlag = q.lvrInvFlag &
				apbReq.pwdata[clock_mode_pkg::IF_LVR_INV_BIT];
			n.wdtRstFlag = q.wdtRstFlag &
				apbReq.pwdata[clock_mode_pkg::IF_WDT_RST_BIT];
		end
		// [R11] low-voltage event wins
		n.lvrFlag = n.lvrFlag | events.lvrEvent;
		// [R12] bad level event wins
		n.lvrInvFlag = n.lvrInvFlag | events.lvrLevelInvalid;
		// [R13] watchdog reset event wins
		n.wdtRstFlag = n.wdtRstFlag | events.wdtCtrlReset;

		// Read data captured in the setup phase
		if (apbReq.psel && !apbReq.penable) begin
			case (apbReq.paddr)
				clock_mode_pkg::ADDR_CLOCK_MODE: begin
					n.rdata = {24'h000000, q.divSel, q.fastWakeEn,
						q.loReady, q.hiReady, q.idleOnHalt, q.highSel};
				end
				clock_mode_pkg::ADDR_IDLE_FLAGS: begin
					// [R10] middle bits read zero
					n.rdata = {24'h000000, q.keepSysclk, 4'h0,
						q.lvrFlag, q.lvrInvFlag, q.wdtRstFlag};
				end
				clock_mode_pkg::ADDR_MODE_STATUS: begin
					n.rdata = {22'h000000,
						(q.sw != clock_mode_pkg::SW_IDLE), q.fastWake,
						q.sel, 1'b0, q.mode};
				end
				default: begin
					n.rdata = 32'h00000000;
				end
			endcase
		end
	end

	// ==================================================================
	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
			q.mode <= clock_mode_pkg::RUN_MODE;
			q.sw <= clock_mode_pkg::SW_IDLE;
			q.sel <= clock_mode_pkg::SEL_RESET;
			q.divSel <= clock_mode_pkg::CLOCK_MODE_RESET
				[clock_mode_pkg::CM_DIV_SEL_LSB +: 3];
			q.fastWakeEn <= clock_mode_pkg::CLOCK_MODE_RESET
				[clock_mode_pkg::CM_FAST_WAKE_BIT];
			q.idleOnHalt <= clock_mode_pkg::CLOCK_MODE_RESET
				[clock_mode_pkg::CM_IDLE_HALT_BIT];
			q.highSel <= clock_mode_pkg::CLOCK_MODE_RESET
				[clock_mode_pkg::CM_HIGH_SEL_BIT];
			q.keepSysclk <= clock_mode_pkg::IDLE_FLAGS_RESET
				[clock_mode_pkg::IF_KEEP_SYSCLK_BIT];
		end else begin
			q <= n;
		end
	end

	// ==================================================================
	// Outputs; zero-wait slave, so ready is constant high
	assign apbRsp.prdata = q.rdata;
	assign apbRsp.pready = 1'b1;
	assign apbRsp.pslverr = apbReq.psel && apbReq.penable &&
		(apbReq.paddr != clock_mode_pkg::ADDR_CLOCK_MODE) &&
		(apbReq.paddr != clock_mode_pkg::ADDR_IDLE_FLAGS) &&
		(apbReq.paddr != clock_mode_pkg::ADDR_MODE_STATUS);
	assign clkEn.sysClkEn = q.sysTick;
	assign clkEn.cpuClkEn = q.cpuTick;
	assign clkEn.subClkEn = q.subTick;
	assign clkEn.hiTapEn = q.taps;
	assign highOscEnable = hiOn;
	assign subOscEnable = subOn;
	assign powerdownSet = q.pdfSet;
	assign timeoutClear = q.toClr;

endmodule : system_clock_mode_control

`default_nettype wire

/* File: verification/clock_mode_checker.sv */
// Checker: port-level assertions for the clock-mode controller
`timescale 1ns/100ps
`default_nettype none

module clock_mode_checker #(
	parameter clock_mode_pkg::high_osc_t HIGH_OSC =
		clock_mode_pkg::FAST_CRYSTAL_OSC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Bus, events and levels
	input wire clock_mode_pkg::apb_req_t apbReq,
	input wire clock_mode_pkg::apb_rsp_t apbRsp,
	input wire clock_mode_pkg::event_in_t events,
	input wire logic wdtEnable,
	input wire logic lowvolt_detect_enable,
	// Clock enables and strobes
	input wire clock_mode_pkg::clk_en_t clkEn,
	input wire logic highOscEnable,
	input wire logic subOscEnable,
	input wire logic powerdownSet,
	input wire logic timeoutClear
);
	// Crystal start-up count, else the smallest count of the other high oscillators
	localparam int HI_WAIT =
		(HIGH_OSC == clock_mode_pkg::FAST_CRYSTAL_OSC) ? 1024 : 2;
	logic idleQ;
	logic [10:0] upCnt;

	// ==================================================================
	// Helper state
	// Idle bit shadow from bus writes; cycles since reset, saturating
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			idleQ <= 1'b1;
			upCnt <= 11'h000;
		end else begin
			if (apbReq.psel && apbReq.penable && apbReq.pwrite &&
				apbReq.paddr == clock_mode_pkg::ADDR_CLOCK_MODE)
				idleQ <= apbReq.pwdata[1];
			if (upCnt != 11'h7FF)
				upCnt <= upCnt + 11'h001;
		end
	end

	// ==================================================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_FLAGS_UNUSED_ZERO: assert property (
		apbReq.psel && apbReq.penable && !apbReq.pwrite &&
		apbReq.paddr == clock_mode_pkg::ADDR_IDLE_FLAGS
		|-> apbRsp.prdata[6:3] == 4'h0)
		else $error("unused flag bits not zero");
	AST_HALT_STROBES: assert property (
		powerdownSet |-> timeoutClear && $past(events.haltReq))
		else $error("halt strobes without halt");
	AST_HALT_PULSE_ONE: assert property (
		powerdownSet |=> !powerdownSet && !timeoutClear)
		else $error("halt strobes longer than one cycle");
	AST_CPU_STOPS: assert property (
		powerdownSet |=> (!clkEn.cpuClkEn) [*2])
		else $error("cpu clock runs after halt");
	AST_DEEP_SLEEP: assert property (
		powerdownSet && !idleQ && !$past(wdtEnable) &&
		!$past(lowvolt_detect_enable) |-> !subOscEnable)
		else $error("sub oscillator left on in deepest sleep");
	AST_SUB_KEPT: assert property (
		powerdownSet && ($past(wdtEnable) || $past(lowvolt_detect_enable))
		|-> subOscEnable)
		else $error("sub oscillator stopped while needed");
	AST_TAPS_STOP: assert property (
		!highOscEnable && !$past(highOscEnable)
		|-> clkEn.hiTapEn == 7'h00)
		else $error("divided taps run with high oscillator off");
	AST_SUB_TICK_STOP: assert property (
		!subOscEnable && !$past(subOscEnable) |-> !clkEn.subClkEn)
		else $error("sub tick with sub oscillator off");
	AST_READY_WAIT: assert property (
		clkEn.sysClkEn |-> upCnt >= HI_WAIT - 1)
		else $error("system clock before oscillator ready");
	// Back-to-back enables only while the undivided high clock ticks
	AST_NO_RUNT: assert property (
		clkEn.sysClkEn ##1 clkEn.sysClkEn |-> clkEn.hiTapEn[0])
		else $error("system enables closer than the source clock");
endmodule : clock_mode_checker

`default_nettype wire

/* File: verification/testbench.sv */
// Testbench: directed scenarios for the clock-mode controller
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, ex, got) begin \
	checks_done++; \
	if ((got) !== (ex)) begin \
		err_count++; \
		$display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
	end \
end

module testbench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic wdtEnable = 1'b0;
	logic lowvolt_detect_enable = 1'b0;
	clock_mode_pkg::apb_req_t apbReq = '0;
	clock_mode_pkg::apb_rsp_t apbRsp;
	clock_mode_pkg::event_in_t events = '0;
	clock_mode_pkg::clk_en_t clkEn;
	logic highOscEnable;
	logic subOscEnable;
	logic powerdownSet;
	logic timeoutClear;
	logic [31:0] rd;
	logic slvErr;
	int err_count = 0;
	int checks_done = 0;
	int cycles = 0;

	// Short sub tick keeps the run brief
	system_clock_mode_control #(.SUB_DIV(4)) uut (.sys_clk, .rst, .apbReq,
		.apbRsp, .events, .wdtEnable, .lowvolt_detect_enable, .clkEn,
		.highOscEnable, .subOscEnable, .powerdownSet, .timeoutClear);

	// ==================================================================
	// Clock, timeout and verdict
	always #25 sys_clk = ~sys_clk;

	// A hang counts as a mismatch
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (err_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run

	// ==================================================================
	// Bus and event tasks
	// One transfer, then an idle cycle so psel never toggles in one step
	task automatic apb(input logic wr, input logic [7:0] ad,
		input logic [31:0] wd);
		// Waits on pready alone; only the bench timeout ends a hang
		apbReq <= '{1'b1, 1'b0, wr, ad, wd};
		@(posedge sys_clk);
		apbReq.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (apbRsp.pready !== 1'b1);
		rd = apbRsp.prdata;
		slvErr = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task automatic poll(input logic [7:0] ad, input logic [31:0] m,
		input logic [31:0] v, input int lim);
		int n;
		n = 0;
		do begin
			apb(1'b0, ad, 32'h0);
			n++;
		end while ((rd & m) !== v && n < lim);
	endtask : poll

	// One-cycle event pulse, bits ordered as the event carrier
	task automatic ev(input logic [4:0] v);
		events <= v;
		@(posedge sys_clk);
		events <= '0;
	endtask : ev

	// Cycles between two system clock enables
	task automatic gap(output int g);
		int n;
		n = 0;
		while (clkEn.sysClkEn !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		g = 0;
		do begin
			@(posedge sys_clk);
			g++;
		end while (clkEn.sysClkEn !== 1'b1 && g < 300);
	endtask : gap

	// ==================================================================
	// Scenarios
	task automatic t_flags();
		for (int k = 0; k < 3; k++) begin
			ev(5'(1 << k));
			apb(1'b0, 8'h04, 32'h0);
			`CHK("flag set", 32'(1 << k), rd)
			apb(1'b1, 8'h04, 32'hFF);
			apb(1'b0, 8'h04, 32'h0);
			`CHK("flag kept", 32'h80 | 32'(1 << k), rd)
			apb(1'b1, 8'h04, 32'h0);
			apb(1'b0, 8'h04, 32'h0);
			`CHK("flag cleared", 32'h0, rd)
		end
	endtask : t_flags

	task automatic t_select();
		logic [3:0] s;
		int e;
		int g;
		for (int i = 0; i < 9; i++) begin
			s = (i == 8) ? 4'h8 : 4'(i);
			apb(1'b1, 8'h00, {24'h0, s[2:0], 4'h0, s[3]});
			poll(8'h08, 32'h3F0, 32'(s) << 4, 500);
			`CHK("selection", 32'(s) << 4, rd & 32'h3F0)
			if (s[3]) e = 1;
			else if (s[2:0] < 3'h2) e = 4;
			else e = 1 << (8 - s[2:0]);
			gap(g);
			`CHK("period", e, g)
			if (s == 4'h0)
				`CHK("hi off", 2'b00, {highOscEnable, |clkEn.hiTapEn})
		end
	endtask : t_select

	task automatic t_halt(input logic idl, input logic keep,
		input logic wdt, input logic lvd, input logic [2:0] md,
		input logic [31:0] rdy);
		int g;
		apb(1'b1, 8'h00, {30'h0, idl, 1'b1});
		apb(1'b1, 8'h04, {24'h0, keep, 7'h07});
		wdtEnable <= wdt;
		lowvolt_detect_enable <= lvd;
		ev(5'h10);
		@(posedge sys_clk);
		`CHK("strobes", 2'b11, {powerdownSet, timeoutClear})
		apb(1'b0, 8'h08, 32'h0);
		`CHK("mode", 32'(md), rd & 32'h7)
		`CHK("cpu off", 1'b0, clkEn.cpuClkEn)
		apb(1'b0, 8'h00, 32'h0);
		`CHK("ready asleep", rdy, rd & 32'hC)
		if (md == 3'h1) begin
			gap(g);
			`CHK("idle period", 1, g)
		end
		ev(5'h08);
		poll(8'h08, 32'h7, 32'h0, 10);
		`CHK("run", 32'h0, rd & 32'h7)
		poll(8'h00, 32'hC, 32'hC, 500);
		`CHK("ready awake", 32'hC, rd & 32'hC)
	endtask : t_halt

	task automatic t_fast(input logic wdt, input logic [31:0] fw);
		int g;
		apb(1'b1, 8'h00, 32'h11);
		wdtEnable <= wdt;
		ev(5'h10);
		repeat (4) @(posedge sys_clk);
		ev(5'h08);
		apb(1'b0, 8'h08, 32'h0);
		`CHK("fast wake", fw, rd & 32'h100)
		if (fw != 32'h0) begin
			gap(g);
			`CHK("sub period", 4, g)
		end
		poll(8'h00, 32'h4, 32'h4, 500);
		apb(1'b0, 8'h08, 32'h0);
		`CHK("fast done", 32'h0, rd & 32'h107)
	endtask : t_fast

	// ==================================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		apb(1'b0, 8'h00, 32'h0);
		`CHK("mode reset", 32'h03, rd & 32'hF7)
		apb(1'b0, 8'h04, 32'h0);
		`CHK("flags reset", 32'h0, rd)
		apb(1'b0, 8'h0C, 32'h0);
		`CHK("unmapped", 33'h1_0000_0000, {slvErr, rd})
		poll(8'h00, 32'hFF, 32'h0F, 500);
		`CHK("ready", 32'h0F, rd)
		t_flags();
		t_select();
		t_halt(1'b1, 1'b1, 1'b0, 1'b0, 3'h1, 32'hC);
		t_halt(1'b1, 1'b0, 1'b0, 1'b0, 3'h2, 32'h8);
		t_halt(1'b0, 1'b0, 1'b1, 1'b0, 3'h3, 32'h8);
		t_halt(1'b0, 1'b0, 1'b0, 1'b1, 3'h3, 32'h8);
		t_halt(1'b0, 1'b0, 1'b0, 1'b0, 3'h4, 32'h0);
		t_fast(1'b1, 32'h100);
		t_fast(1'b0, 32'h0);
		complete_run();
	end
endmodule : testbench

bind system_clock_mode_control clock_mode_checker #(.HIGH_OSC(HIGH_OSC)) chk (
	.sys_clk, .rst, .apbReq, .apbRsp, .events, .wdtEnable,
	.lowvolt_detect_enable, .clkEn, .highOscEnable, .subOscEnable,
	.powerdownSet, .timeoutClear);

`default_nettype wire
